/* File: logic/cpu_flags_and_stack_pointer.sv */
// Condition flags and stack pointer of an 8-bit CPU core.
// Assumes the execution unit and interrupt sequencer drive it on the core clock.
//
// Summary of operation
// - Half carry from bit 3 on add.
// - Negative flag copies result bit 7.
// - Zero flag set when result is zero.
// - Carry flag reflects arithmetic overflow or underflow.
// - Set and clear carry instructions force carry.
// - Bit test, shift, rotate also update carry.
// - Decode priority bits into four levels.
// - Interrupt entry loads priority from registers.
// - Software instructions may rewrite priority bits.
// - Flags pushed and popped as whole.
// - Decrement after push, increment before pop.
// - Upper stack pointer byte fixed.
// - Reset and reinit set low byte ones.
// - Load reads and writes low byte.
// - Stack pointer wraps silently both ways.
// - Interrupt saves program counter low first.
// - Call two bytes, interrupt five bytes.
`timescale 1ns/1ns
`include "cpu_flags_defines.svh"

module cpu_flags_and_stack_pointer (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Flag updates from the execution unit.
  input wire cpu_flags_pkg::flag_req_s flag_req,
  // Software priority changes and interrupt entry.
  input wire logic prio_write,
  input wire logic [1:0] prio_value,
  input wire logic irq_entry,
  input wire logic [1:0] irq_priority_regs,
  // Whole flag register write, from pop or load.
  input wire logic flags_write,
  input wire logic [7:0] flags_wdata,
  // Stack pointer control.
  input wire logic stack_reinit_instruction,
  input wire logic sp_low_write,
  input wire logic [7:0] sp_low_wdata,
  input wire cpu_flags_pkg::stack_op_e stack_op,
  input wire logic stack_step,
  // Register views.
  output logic [7:0] condition_flags,
  output logic [15:0] stack_pointer,
  output logic [1:0] priority_level,
  output logic irq_disabled,
  // Stack sequencing status.
  output logic stack_busy,
  output logic [2:0] bytes_left
);

  cpu_flags_pkg::state_s state_ff;
  cpu_flags_pkg::state_s nxt_state;

  // Priority decode: bits high,low to level 0..3.
  function automatic logic [1:0] prio_level(input logic [1:0] hl);
    unique case (hl)
      2'h2: prio_level = 2'h0;
      2'h1: prio_level = 2'h1;
      2'h0: prio_level = 2'h2;
      2'h3: prio_level = 2'h3;
    endcase
  endfunction : prio_level

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------

  // Flags update first, then the stack pointer and its byte sequencing.
  always_comb begin
    nxt_state = state_ff;
    if (flag_req.upd_h) begin
      nxt_state.flags[`CF_BIT_H] = flag_req.half_carry;
    end
    if (flag_req.upd_nz) begin
      nxt_state.flags[`CF_BIT_N] = flag_req.result[`CF_BIT_MSB];
      nxt_state.flags[`CF_BIT_Z] = (flag_req.result == 8'h00);
    end
    if (flag_req.upd_c) begin
      nxt_state.flags[`CF_BIT_C] = flag_req.carry;
    end
    if (flag_req.set_c) begin
      nxt_state.flags[`CF_BIT_C] = 1'b1;
    end else if (flag_req.clr_c) begin
      nxt_state.flags[`CF_BIT_C] = 1'b0;
    end
    if (prio_write) begin
      nxt_state.flags[`CF_BIT_PRIO_HI] = prio_value[1];
      nxt_state.flags[`CF_BIT_PRIO_LO] = prio_value[0];
    end
    if (flags_write) begin
      nxt_state.flags = flags_wdata | `CF_FIXED_ONES;
    end
    if (irq_entry) begin
      nxt_state.flags[`CF_BIT_PRIO_HI] = irq_priority_regs[1];
      nxt_state.flags[`CF_BIT_PRIO_LO] = irq_priority_regs[0];
    end
    // Start a stack sequence; one byte moves per stack_step.
    if (state_ff.seq == cpu_flags_pkg::SEQ_IDLE) begin
      unique case (stack_op)
        cpu_flags_pkg::STK_PUSH: begin
          nxt_state.seq = cpu_flags_pkg::SEQ_PUSHING;
          nxt_state.left = `SINGLE_BYTES;
        end
        cpu_flags_pkg::STK_POP: begin
          nxt_state.seq = cpu_flags_pkg::SEQ_POPPING;
          nxt_state.left = `SINGLE_BYTES;
        end
        cpu_flags_pkg::STK_CALL: begin
          nxt_state.seq = cpu_flags_pkg::SEQ_PUSHING;
          nxt_state.left = `CALL_BYTES;
        end
        cpu_flags_pkg::STK_IRQ: begin
          nxt_state.seq = cpu_flags_pkg::SEQ_PUSHING;
          nxt_state.left = `IRQ_BYTES;
        end
        cpu_flags_pkg::STK_IRQ_RET: begin
          nxt_state.seq = cpu_flags_pkg::SEQ_POPPING;
          nxt_state.left = `IRQ_BYTES;
        end
        default: begin
          nxt_state.seq = cpu_flags_pkg::SEQ_IDLE;
        end
      endcase
    end else if (stack_step) begin
      // 8-bit arithmetic wraps silently inside the fixed page.
      if (state_ff.seq == cpu_flags_pkg::SEQ_PUSHING) begin
        nxt_state.sp_low = state_ff.sp_low - `SP_ONE;
      end else begin
        nxt_state.sp_low = state_ff.sp_low + `SP_ONE;
      end
      nxt_state.left = state_ff.left - 3'h1;
      if (state_ff.left == 3'h1) begin
        nxt_state.seq = cpu_flags_pkg::SEQ_IDLE;
      end
    end
    if (sp_low_write) begin
      nxt_state.sp_low = sp_low_wdata;
    end
    if (stack_reinit_instruction) begin
      nxt_state.sp_low = `SP_LOW_RESET;
      nxt_state.seq = cpu_flags_pkg::SEQ_IDLE;
      nxt_state.left = 3'h0;
    end
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------

  // Reset puts the pointer at the top of the stack page.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.flags <= `CF_RESET;
      state_ff.sp_low <= `SP_LOW_RESET;
      state_ff.seq <= cpu_flags_pkg::SEQ_IDLE;
      state_ff.left <= 3'h0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Register views; the pointer's upper byte is a constant.
  assign condition_flags = state_ff.flags | `CF_FIXED_ONES;
  assign stack_pointer = {`SP_UPPER_BYTE, state_ff.sp_low};
  assign priority_level = prio_level({state_ff.flags[`CF_BIT_PRIO_HI],
                                      state_ff.flags[`CF_BIT_PRIO_LO]});
  assign irq_disabled = (priority_level == 2'h3);
  assign stack_busy = (state_ff.seq != cpu_flags_pkg::SEQ_IDLE);
  assign bytes_left = state_ff.left;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------

  // Upper byte never moves.
  sp_upper_fixed_a: assert property (@(posedge clock) disable iff (!rst_n)
    stack_pointer[15:8] == `SP_UPPER_BYTE) else $error("Stack page moved.");

  // Reinit lands on the top of the page.
  sp_reinit_top_a: assert property (@(posedge clock) disable iff (!rst_n)
    stack_reinit_instruction |=> stack_pointer[7:0] == `SP_LOW_RESET)
    else $error("Reinit missed top.");

  // Top bits read as one.
  flags_top_ones_a: assert property (@(posedge clock) disable iff (!rst_n)
    condition_flags[7:6] == 2'h3) else $error("Top flag bits not one.");

  // Zero flag follows result.
  zero_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    flag_req.upd_nz && !flags_write |=>
      condition_flags[`CF_BIT_Z] == ($past(flag_req.result) == 8'h00))
    else $error("Zero flag wrong.");

  // Negative flag follows result bit 7.
  neg_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    flag_req.upd_nz && !flags_write |=>
      condition_flags[`CF_BIT_N] == $past(flag_req.result[7]))
    else $error("Negative flag wrong.");

  // Set carry forces one.
  set_carry_a: assert property (@(posedge clock) disable iff (!rst_n)
    flag_req.set_c && !flags_write |=> condition_flags[`CF_BIT_C])
    else $error("Carry not set.");

  // Interrupt entry loads priority.
  irq_prio_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    irq_entry |=> {condition_flags[`CF_BIT_PRIO_HI], condition_flags[`CF_BIT_PRIO_LO]}
      == $past(irq_priority_regs)) else $error("Priority not loaded.");

  // Push step decrements by one with wrap.
  push_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff.seq == cpu_flags_pkg::SEQ_PUSHING && stack_step && !sp_low_write
      && !stack_reinit_instruction |=>
      stack_pointer[7:0] == 8'($past(stack_pointer[7:0]) - 8'h01))
    else $error("Push step wrong.");

  // Interrupt frame takes five bytes.
  irq_frame_a: assert property (@(posedge clock) disable iff (!rst_n)
    !stack_busy && stack_op == cpu_flags_pkg::STK_IRQ && !stack_reinit_instruction
      |=> bytes_left == 3'h5) else $error("Interrupt frame size wrong.");

  // Half carry follows the adder's bit 3 carry.
  half_carry_a: assert property (@(posedge clock) disable iff (!rst_n)
    flag_req.upd_h && !flags_write |=>
      condition_flags[`CF_BIT_H] == $past(flag_req.half_carry))
    else $error("Half carry flag wrong.");

  // Carry follows the operation when no forcing request competes.
  carry_update_a: assert property (@(posedge clock) disable iff (!rst_n)
    flag_req.upd_c && !flag_req.set_c && !flag_req.clr_c && !flags_write |=>
      condition_flags[`CF_BIT_C] == $past(flag_req.carry))
    else $error("Carry flag wrong.");

  // Clear carry forces zero unless set carry comes with it.
  clear_carry_a: assert property (@(posedge clock) disable iff (!rst_n)
    flag_req.clr_c && !flag_req.set_c && !flags_write |=>
      !condition_flags[`CF_BIT_C])
    else $error("Carry not cleared.");

  // Flags hold while nothing asks for a change.
  flags_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !flag_req.upd_nz && !flag_req.upd_h && !flag_req.upd_c && !flag_req.set_c
      && !flag_req.clr_c && !prio_write && !flags_write && !irq_entry |=>
      $stable(condition_flags))
    else $error("Flags changed without a request.");

  // Software write of the priority bits.
  prio_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    prio_write && !flags_write && !irq_entry |=>
      {condition_flags[`CF_BIT_PRIO_HI], condition_flags[`CF_BIT_PRIO_LO]}
      == $past(prio_value))
    else $error("Priority write lost.");

  // Whole register load keeps the top two bits at one.
  flags_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    flags_write && !irq_entry |=>
      condition_flags == ($past(flags_wdata) | `CF_FIXED_ONES))
    else $error("Flag register load wrong.");

  // Priority bits one, zero give the lowest level.
  prio_lowest_a: assert property (@(posedge clock) disable iff (!rst_n)
    {condition_flags[`CF_BIT_PRIO_HI], condition_flags[`CF_BIT_PRIO_LO]} == 2'h2
      |-> priority_level == 2'h0 && !irq_disabled)
    else $error("Lowest level decode wrong.");

  // Priority bits zero, one give level one.
  prio_level_one_a: assert property (@(posedge clock) disable iff (!rst_n)
    {condition_flags[`CF_BIT_PRIO_HI], condition_flags[`CF_BIT_PRIO_LO]} == 2'h1
      |-> priority_level == 2'h1 && !irq_disabled)
    else $error("Level one decode wrong.");

  // Priority bits zero, zero give level two.
  prio_level_two_a: assert property (@(posedge clock) disable iff (!rst_n)
    {condition_flags[`CF_BIT_PRIO_HI], condition_flags[`CF_BIT_PRIO_LO]} == 2'h0
      |-> priority_level == 2'h2 && !irq_disabled)
    else $error("Level two decode wrong.");

  // Both priority bits set give the top level and mask interrupts.
  prio_highest_a: assert property (@(posedge clock) disable iff (!rst_n)
    {condition_flags[`CF_BIT_PRIO_HI], condition_flags[`CF_BIT_PRIO_LO]} == 2'h3
      |-> priority_level == 2'h3 && irq_disabled)
    else $error("Top level decode wrong.");

  // Pop step increments by one with wrap.
  pop_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff.seq == cpu_flags_pkg::SEQ_POPPING && stack_step && !sp_low_write
      && !stack_reinit_instruction |=>
      stack_pointer[7:0] == 8'($past(stack_pointer[7:0]) + `SP_ONE))
    else $error("Pop step wrong.");

  // Push below the page bottom lands on its top.
  push_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff.seq == cpu_flags_pkg::SEQ_PUSHING && stack_step && stack_pointer[7:0] == 8'h00
      && !sp_low_write && !stack_reinit_instruction |=>
      stack_pointer[7:0] == `SP_LOW_RESET)
    else $error("Push wrap wrong.");

  // Pop above the page top lands on its bottom.
  pop_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_ff.seq == cpu_flags_pkg::SEQ_POPPING && stack_step
      && stack_pointer[7:0] == `SP_LOW_RESET && !sp_low_write && !stack_reinit_instruction
      |=> stack_pointer[7:0] == 8'h00)
    else $error("Pop wrap wrong.");

  // Direct load of the low byte.
  sp_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    sp_low_write && !stack_reinit_instruction |=>
      stack_pointer[7:0] == $past(sp_low_wdata))
    else $error("Pointer load lost.");

  // A single push or pop moves one byte.
  single_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
    !stack_busy && (stack_op == cpu_flags_pkg::STK_PUSH
      || stack_op == cpu_flags_pkg::STK_POP) && !stack_reinit_instruction
      |=> stack_busy && bytes_left == `SINGLE_BYTES)
    else $error("Single byte frame wrong.");

  // Subroutine call frame takes two bytes.
  call_frame_a: assert property (@(posedge clock) disable iff (!rst_n)
    !stack_busy && stack_op == cpu_flags_pkg::STK_CALL && !stack_reinit_instruction
      |=> stack_busy && bytes_left == `CALL_BYTES) else $error("Call frame size wrong.");

  // Interrupt return frame takes five bytes.
  irq_return_frame_a: assert property (@(posedge clock) disable iff (!rst_n)
    !stack_busy && stack_op == cpu_flags_pkg::STK_IRQ_RET && !stack_reinit_instruction
      |=> stack_busy && bytes_left == `IRQ_BYTES) else $error("Return frame size wrong.");

  // Interrupt entry leaves the pointer on the first free byte.
  irq_first_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
    !stack_busy && stack_op == cpu_flags_pkg::STK_IRQ && !sp_low_write
      && !stack_reinit_instruction |=> stack_busy && $stable(stack_pointer))
    else $error("Interrupt entry moved the pointer.");

  // Each step uses up one byte of the frame.
  step_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    stack_busy && stack_step && !stack_reinit_instruction |=>
      bytes_left == 3'($past(bytes_left) - 3'h1))
    else $error("Byte count wrong.");

  // Pointer holds between steps of a frame.
  busy_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    stack_busy && !stack_step && !sp_low_write && !stack_reinit_instruction |=>
      $stable(stack_pointer))
    else $error("Pointer moved between steps.");

  // Steps while idle are ignored.
  idle_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    !stack_busy && stack_step && stack_op == cpu_flags_pkg::STK_IDLE && !sp_low_write
      && !stack_reinit_instruction |=> !stack_busy && $stable(stack_pointer))
    else $error("Idle step moved the pointer.");

  // Reinit aborts any frame in progress.
  reinit_abort_a: assert property (@(posedge clock) disable iff (!rst_n)
    stack_reinit_instruction |=> !stack_busy && bytes_left == 3'h0)
    else $error("Reinit left a frame running.");

endmodule : cpu_flags_and_stack_pointer

/* File: logic/cpu_flags_defines.svh */
// Bit positions, reset values and stack figures for the flags and stack pointer block.
// Assumes it is included by its bare name from the design file.
`ifndef CPU_FLAGS_DEFINES_SVH
`define CPU_FLAGS_DEFINES_SVH

`define CF_BIT_C 0
`define CF_BIT_Z 1
`define CF_BIT_N 2
`define CF_BIT_PRIO_LO 3
`define CF_BIT_H 4
`define CF_BIT_PRIO_HI 5
`define CF_BIT_MSB 7
`define CF_FIXED_ONES 8'hC0
`define CF_RESET 8'hE8
`define SP_UPPER_BYTE 8'h01
`define SP_LOW_RESET 8'hFF
`define SP_ONE 8'h01
`define CALL_BYTES 3'h2
`define SINGLE_BYTES 3'h1
`define IRQ_BYTES 3'h5

`endif

/* File: logic/cpu_flags_pkg.sv */
// Types shared by the flags and stack pointer block.
// Assumes cpu_flags_defines.svh is on the include path.
package cpu_flags_pkg;

  // Flag update request from the execution unit.
  typedef struct packed {
    logic upd_nz;
    logic upd_h;
    logic upd_c;
    logic set_c;
    logic clr_c;
    logic [7:0] result;
    logic half_carry;
    logic carry;
  } flag_req_s;

  // Stack operation kinds.
  typedef enum logic [2:0] {
    STK_IDLE,
    STK_PUSH,
    STK_POP,
    STK_CALL,
    STK_IRQ,
    STK_IRQ_RET
  } stack_op_e;

  // Stack sequencing state.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PUSHING,
    SEQ_POPPING
  } seq_e;

  // All state of the block.
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] sp_low;
    seq_e seq;
    logic [2:0] left;
  } state_s;

endpackage : cpu_flags_pkg

/* File: verification/stack_sequencer_model.sv */
// Stand-in for the execution unit that walks stack frames.
// Assumes the flags and stack pointer block shares its clock and reset.
`timescale 1ns/1ns

module stack_sequencer_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Frame request from the bench.
  input wire logic go,
  input wire cpu_flags_pkg::stack_op_e kind,
  input wire logic gap,
  // Stack pointer control toward the block.
  output cpu_flags_pkg::stack_op_e stack_op,
  output logic stack_step,
  output logic done
);
  logic [2:0] cnt;
  logic pause;

  // Issues the operation, then one step per byte, idling between steps when slow.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_op <= cpu_flags_pkg::STK_IDLE;
      stack_step <= 1'b0;
      cnt <= 3'h0;
      pause <= 1'b0;
    end else begin
      stack_op <= go ? kind : cpu_flags_pkg::STK_IDLE;
      stack_step <= 1'b0;
      if (go) begin
        // Calls take two bytes, interrupt frames five, the caller orders the bytes.
        cnt <= (kind == cpu_flags_pkg::STK_CALL) ? 3'h2 :
          (kind == cpu_flags_pkg::STK_IRQ || kind == cpu_flags_pkg::STK_IRQ_RET) ? 3'h5 :
          (kind == cpu_flags_pkg::STK_IDLE) ? 3'h0 : 3'h1;
      end else if (cnt != 3'h0 && pause) begin
        pause <= 1'b0;
      end else if (cnt != 3'h0) begin
        stack_step <= 1'b1;
        cnt <= cnt - 3'h1;
        pause <= gap;
      end
    end
  end

  // Frame finished once no step is pending.
  assign done = (cnt == 3'h0) && !stack_step;
endmodule : stack_sequencer_model

/* File: verification/tb.sv */
// Self-checking bench for the flags and stack pointer block.
// Assumes the design package and the sequencer model are compiled first.
`timescale 1ns/1ns

module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  cpu_flags_pkg::flag_req_s flag_req = '0;
  logic prio_write = 1'b0;
  logic [1:0] prio_value = 2'h0;
  logic irq_entry = 1'b0;
  logic [1:0] irq_priority_regs = 2'h0;
  logic flags_write = 1'b0;
  logic [7:0] flags_wdata = 8'h00;
  logic stack_reinit_instruction = 1'b0;
  logic sp_low_write = 1'b0;
  logic [7:0] sp_low_wdata = 8'h00;
  logic go = 1'b0;
  logic gap = 1'b0;
  logic done;
  cpu_flags_pkg::stack_op_e kind = cpu_flags_pkg::STK_IDLE;
  cpu_flags_pkg::stack_op_e stack_op;
  logic stack_step;
  logic [7:0] condition_flags;
  logic [15:0] stack_pointer;
  logic [1:0] priority_level;
  logic irq_disabled;
  logic stack_busy;
  logic [2:0] bytes_left;
  logic [7:0] ef;
  logic [1:0] lv;
  int miscompares = 0;
  int num_checks = 0;

  always #20 clock = ~clock;

  cpu_flags_and_stack_pointer dut (.clock(clock), .rst_n(rst_n), .flag_req(flag_req),
    .prio_write(prio_write), .prio_value(prio_value), .irq_entry(irq_entry),
    .irq_priority_regs(irq_priority_regs), .flags_write(flags_write),
    .flags_wdata(flags_wdata), .stack_reinit_instruction(stack_reinit_instruction),
    .sp_low_write(sp_low_write), .sp_low_wdata(sp_low_wdata), .stack_op(stack_op),
    .stack_step(stack_step), .condition_flags(condition_flags),
    .stack_pointer(stack_pointer), .priority_level(priority_level),
    .irq_disabled(irq_disabled), .stack_busy(stack_busy), .bytes_left(bytes_left));

  stack_sequencer_model far (.clock(clock), .rst_n(rst_n), .go(go), .kind(kind), .gap(gap),
    .stack_op(stack_op), .stack_step(stack_step), .done(done));

  // Compares one value and reports a mismatch.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Drops every pulse at the edge that takes the request, then lets it land.
  task automatic fire;
    @(posedge clock);
    flag_req <= '0;
    prio_write <= 1'b0;
    irq_entry <= 1'b0;
    flags_write <= 1'b0;
    stack_reinit_instruction <= 1'b0;
    sp_low_write <= 1'b0;
    go <= 1'b0;
    #1;
  endtask : fire

  // Starts a frame in the model, then waits for it under a bound and checks the pointer.
  task automatic frame(input cpu_flags_pkg::stack_op_e k, input logic g, input logic [7:0] el);
    @(posedge clock);
    go <= 1'b1;
    kind <= k;
    gap <= g;
    fire;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      #1;
      if (done && !stack_busy) break;
    end
    check({done, stack_busy}, 16'h0002);
    check(stack_pointer, {8'h01, el});
  endtask : frame

  // Prints counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Cuts a hang short.
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    give_verdict;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    #1;
    check(stack_pointer, 16'h01FF);
    check({condition_flags, 5'h00, stack_busy, 2'h0}, 16'hE800);
    @(posedge clock);
    rst_n <= 1'b1;
    ef = 8'hE8;
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      flag_req <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'(i * 8'h7F), i[0], i[1]};
      fire;
      ef = {ef[7:5], i[0], ef[3], (i == 2), (i == 0), i[1]};
      check(condition_flags, ef);
    end
    @(posedge clock);
    flag_req <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0};
    fire;
    check(condition_flags[0], 1'b1);
    @(posedge clock);
    flag_req <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0};
    fire;
    check(condition_flags[0], 1'b0);
    $display("test flags done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      prio_write <= 1'b1;
      prio_value <= 2'(i);
      fire;
      lv = (i == 2) ? 2'h0 : (i == 1) ? 2'h1 : (i == 0) ? 2'h2 : 2'h3;
      check({condition_flags[5], condition_flags[3], priority_level}, {2'(i), lv});
      check(irq_disabled, (i == 3));
    end
    @(posedge clock);
    prio_write <= 1'b1;
    prio_value <= 2'h3;
    irq_entry <= 1'b1;
    irq_priority_regs <= 2'h1;
    fire;
    check({priority_level, irq_disabled}, {2'h1, 1'b0});
    @(posedge clock);
    flags_write <= 1'b1;
    flags_wdata <= 8'h00;
    fire;
    check({condition_flags, priority_level}, {8'hC0, 2'h2});
    $display("test priority done");
    @(posedge clock);
    sp_low_write <= 1'b1;
    sp_low_wdata <= 8'h01;
    fire;
    check(stack_pointer, 16'h0101);
    frame(cpu_flags_pkg::STK_CALL, 1'b1, 8'hFF);
    frame(cpu_flags_pkg::STK_IRQ_RET, 1'b0, 8'h04);
    frame(cpu_flags_pkg::STK_IRQ, 1'b1, 8'hFF);
    frame(cpu_flags_pkg::STK_PUSH, 1'b0, 8'hFE);
    frame(cpu_flags_pkg::STK_POP, 1'b0, 8'hFF);
    @(posedge clock);
    go <= 1'b1;
    kind <= cpu_flags_pkg::STK_IRQ;
    fire;
    @(posedge clock);
    #1;
    check({stack_busy, bytes_left}, 16'h000D);
    @(posedge clock);
    stack_reinit_instruction <= 1'b1;
    fire;
    check({stack_pointer[15:1], stack_busy}, 16'h01FE);
    repeat (8) @(posedge clock);
    check(stack_pointer, 16'h01FF);
    $display("test stack done");
    give_verdict;
  end
endmodule : tb
